// ==== hw/stc_pkg.sv ====
// Package for the SDRAM timing and refresh control block
package stc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] STC_ADDR_CONFIG = 8'h00;
    localparam logic [7:0] STC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] STC_ADDR_MASK = 8'h08;
    localparam logic [31:0] STC_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] STC_CONFIG_WMASK = 32'h003F_3F00;
    localparam int STC_RC_LSB = 8;
    localparam int STC_CMD_DLY_BIT = 11;
    localparam int STC_PAR_EN_BIT = 12;
    localparam int STC_CPU_PAR_BIT = 13;
    localparam int STC_REF_LSB = 16;
    localparam logic [3:0] STC_RC_BASE = 4'h3;
    localparam logic [2:0] STC_RC_RESERVED = 3'h0;
    localparam logic [5:0] STC_REF_OFF = 6'h00;
    localparam logic [1:0] STC_RESP_OKAY = 2'h0;
    localparam logic [1:0] STC_RESP_SLVERR = 2'h2;
    // Status bits: refresh issued, parity error, reserved row cycle code
    localparam int STC_EV_REF = 0;
    localparam int STC_EV_PERR = 1;
    localparam int STC_EV_RCBAD = 2;
    localparam int STC_EV_W = 3;
    // ****************************************
    // Timing
    // ****************************************
    localparam int STC_CLK_MHZ = 100;
    localparam int STC_TICK_NS = 160;
    localparam int STC_PRESCALE = (STC_TICK_NS * STC_CLK_MHZ) / 1000;
    localparam logic [4:0] STC_PRESCALE_MAX = 5'(STC_PRESCALE - 1);

    typedef enum logic [3:0] {
        STC_IDLE = 4'h1,
        STC_ADDR = 4'h2,
        STC_WAIT = 4'h4,
        STC_CS = 4'h8
    } stc_seq_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } stc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } stc_axi_rsp_t;

    typedef struct packed {
        logic cmd_valid;
        logic cs;
        logic refresh;
    } stc_mem_cmd_t;

    typedef struct packed {
        logic [31:0] config_reg;
        logic [STC_EV_W-1:0] status;
        logic [STC_EV_W-1:0] mask;
        logic aw_got;
        logic [31:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [4:0] pre_cnt;
        logic [5:0] ref_cnt;
        logic ref_pend;
        stc_seq_t seq;
        logic [3:0] rc_cnt;
        stc_mem_cmd_t mem;
        logic [3:0] par_out;
        logic par_oe_b;
        logic par_err;
    } stc_state_t;
endpackage

// ==== hw/stc_sdram_timing.sv ====
// SDRAM timing, refresh and parity control with AXI4-Lite registers
// Notes on behaviour
// (RULE1) After an auto-refresh no row activate is allowed before the row cycle time, codes 1..7 give 4..10.
// (RULE2) The command-drive bit adds one cycle to the effective row cycle time.
// (RULE3) Chip select comes with address valid when the drive bit is 0, one cycle later when 1.
// (RULE4) Parity disabled keeps the four parity pins undriven and skips read checks.
// (RULE5) Parity enabled drives the parity pins on writes and checks them on reads.
// (RULE6) With processor parity set, host writes get no generated parity.
// (RULE7) Software should set processor parity only together with parity enable.
// (RULE8) A 6-bit interval of prescaled ticks times refreshes, zero disables refresh.
// (RULE9) An expired interval issues refresh only at the next arbitration point.
// (RULE10) The refresh timer reloads and keeps counting at once on expiry.
// (RULE11) One auto-refresh refreshes all arrays together.
// (RULE12) All counts are in cycles of the core memory clock; the refresh interval instead counts prescaled ticks of 16 cycles.
// (RULE13) The tick comes from a fixed prescaler and unused bits read as zero.
`timescale 1ns/1ps
`default_nettype none
module stc_sdram_timing (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire stc_pkg::stc_axi_req_t axi_req,
    output var stc_pkg::stc_axi_rsp_t axi_rsp,
    input wire logic arb_point,
    input wire logic activate_req,
    output logic activate_ok,
    input wire logic wr_active,
    input wire logic wr_from_cpu,
    input wire logic [31:0] wr_data,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    input wire logic [3:0] parity_in,
    output logic [3:0] parity_out,
    output logic parity_oe_b,
    output var stc_pkg::stc_mem_cmd_t mem_cmd,
    output logic irq
);
    import stc_pkg::*;

    stc_state_t s;
    stc_state_t next_s;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] byte_par(input logic [31:0] d);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i < 4; i++) begin
            p[i] = ^d[i*8 +: 8];
        end
        return p;
    endfunction

    function automatic logic [3:0] rc_cycles(input logic [31:0] c);
        logic [3:0] n;
        n = STC_RC_BASE + {1'b0, c[STC_RC_LSB +: 3]}; // [RULE1]
        if (c[STC_CMD_DLY_BIT]) begin
            n = n + 4'h1; // [RULE2]
        end
        return n;
    endfunction

    logic [31:0] rd_word;
    logic wr_fire;
    logic ar_fire;
    logic tick;
    logic ref_expire;

    always_comb begin
        unique case (axi_req.araddr[7:0])
            STC_ADDR_CONFIG: rd_word = s.config_reg & STC_CONFIG_WMASK; // [RULE13]
            STC_ADDR_STATUS: rd_word = 32'(s.status);
            STC_ADDR_MASK: rd_word = 32'(s.mask);
            default: rd_word = 32'h0000_0000;
        endcase
    end

    assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
    assign ar_fire = axi_req.arvalid && !s.rvalid;
    assign tick = (s.pre_cnt == STC_PRESCALE_MAX); // [RULE13] [RULE12]
    assign ref_expire = tick && (s.config_reg[STC_REF_LSB +: 6] != STC_REF_OFF)
        && (s.ref_cnt == 6'h01); // [RULE8]

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [31:0] wm;
        wm = '0;
        next_s = s;
        // AXI write channel
        if (axi_req.awvalid && !s.aw_got) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s.w_got) begin
            next_s.w_got = 1'b1;
            next_s.w_data = axi_req.wdata;
            next_s.w_strb = axi_req.wstrb;
        end
        if (s.bvalid && axi_req.bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = STC_RESP_OKAY;
            for (int i = 0; i < 4; i++) begin
                wm[i*8 +: 8] = {8{s.w_strb[i]}};
            end
            unique case (s.aw_addr[7:0])
                STC_ADDR_CONFIG: next_s.config_reg =
                    (s.config_reg & ~(wm & STC_CONFIG_WMASK)) |
                    (s.w_data & wm & STC_CONFIG_WMASK);
                STC_ADDR_MASK: if (s.w_strb[0]) begin
                    next_s.mask = s.w_data[STC_EV_W-1:0];
                end
                STC_ADDR_STATUS: ;
                default: next_s.bresp = STC_RESP_SLVERR;
            endcase
        end
        // AXI read channel, read of status clears it
        if (s.rvalid && axi_req.rready) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_word;
            next_s.rresp = (axi_req.araddr[7:0] == STC_ADDR_CONFIG ||
                axi_req.araddr[7:0] == STC_ADDR_STATUS ||
                axi_req.araddr[7:0] == STC_ADDR_MASK) ? STC_RESP_OKAY : STC_RESP_SLVERR;
            if (axi_req.araddr[7:0] == STC_ADDR_STATUS) begin
                next_s.status = '0;
            end
        end
        // Prescaler and refresh interval timer
        next_s.pre_cnt = tick ? 5'h00 : s.pre_cnt + 5'h01; // [RULE13]
        if (s.config_reg[STC_REF_LSB +: 6] == STC_REF_OFF) begin
            next_s.ref_cnt = STC_REF_OFF; // [RULE8]
            next_s.ref_pend = 1'b0;
        end else if (tick) begin
            if (s.ref_cnt <= 6'h01) begin
                next_s.ref_cnt = s.config_reg[STC_REF_LSB +: 6]; // [RULE10]
            end else begin
                next_s.ref_cnt = s.ref_cnt - 6'h01;
            end
        end
        if (ref_expire) begin
            next_s.ref_pend = 1'b1; // [RULE10]
        end
        // Refresh command sequencer
        next_s.mem = '0;
        unique case (s.seq)
            STC_IDLE: if (s.ref_pend && arb_point) begin
                next_s.ref_pend = ref_expire; // [RULE9]
                next_s.mem.cmd_valid = 1'b1;
                next_s.mem.refresh = 1'b1; // [RULE11]
                next_s.mem.cs = !s.config_reg[STC_CMD_DLY_BIT]; // [RULE3]
                next_s.seq = s.config_reg[STC_CMD_DLY_BIT] ? STC_CS : STC_WAIT;
                next_s.rc_cnt = rc_cycles(s.config_reg); // [RULE1]
                next_s.status[STC_EV_REF] = 1'b1;
                if (s.config_reg[STC_RC_LSB +: 3] == STC_RC_RESERVED) begin
                    next_s.status[STC_EV_RCBAD] = 1'b1;
                end
            end
            STC_CS: begin
                next_s.mem.cmd_valid = 1'b1;
                next_s.mem.refresh = 1'b1;
                next_s.mem.cs = 1'b1; // [RULE3]
                next_s.rc_cnt = s.rc_cnt - 4'h1;
                next_s.seq = STC_WAIT;
            end
            STC_WAIT: begin
                if (s.rc_cnt <= 4'h1) begin
                    next_s.seq = STC_IDLE; // [RULE1]
                end else begin
                    next_s.rc_cnt = s.rc_cnt - 4'h1;
                end
            end
            STC_ADDR: next_s.seq = STC_IDLE;
            default: next_s.seq = STC_IDLE;
        endcase
        // Parity generation and check
        next_s.par_oe_b = 1'b1; // [RULE4]
        next_s.par_err = 1'b0;
        if (s.config_reg[STC_PAR_EN_BIT]) begin
            if (wr_active && !(wr_from_cpu && s.config_reg[STC_CPU_PAR_BIT])) begin
                next_s.par_oe_b = 1'b0; // [RULE5] [RULE6]
                next_s.par_out = byte_par(wr_data);
            end
            if (rd_valid && byte_par(rd_data) != parity_in) begin
                next_s.par_err = 1'b1; // [RULE5]
                next_s.status[STC_EV_PERR] = 1'b1;
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s <= '0;
            s.config_reg <= STC_CONFIG_RESET;
            s.seq <= STC_IDLE;
            s.par_oe_b <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        axi_rsp.awready = !s.aw_got;
        axi_rsp.wready = !s.w_got;
        axi_rsp.bvalid = s.bvalid;
        axi_rsp.bresp = s.bresp;
        axi_rsp.arready = !s.rvalid;
        axi_rsp.rvalid = s.rvalid;
        axi_rsp.rdata = s.rdata;
        axi_rsp.rresp = s.rresp;
    end
    assign activate_ok = (s.seq == STC_IDLE) && !(s.ref_pend && arb_point); // [RULE1]
    assign mem_cmd = s.mem;
    assign parity_out = s.par_out;
    assign parity_oe_b = s.par_oe_b;
    assign irq = |(s.status & s.mask);

    // ****************************************
    // Assertions
    // ****************************************
    sequence refresh_start;
        s.seq == STC_IDLE && next_s.seq != STC_IDLE;
    endsequence

    sequence cs_late;
        !mem_cmd.cs ##1 (mem_cmd.cs && mem_cmd.cmd_valid);
    endsequence

    // Cycles since refresh start and cycles needed
    logic [3:0] gap_cnt;
    logic [3:0] gap_need;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gap_cnt <= 4'h0;
            gap_need <= 4'h0;
        end else if (s.seq == STC_IDLE && next_s.seq != STC_IDLE) begin
            gap_cnt <= 4'h0;
            gap_need <= rc_cycles(s.config_reg); // [RULE1]
        end else if (!activate_ok && gap_cnt != 4'hF) begin
            gap_cnt <= gap_cnt + 4'h1;
        end
    end

    a_rc_min_gap: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE1]
        refresh_start ##1 1'b1 |-> !activate_ok [*4])
        else $error("activate allowed inside row cycle time");
    a_cs_delayed: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE3]
        mem_cmd.cmd_valid && !mem_cmd.cs |=> mem_cmd.cs && mem_cmd.cmd_valid)
        else $error("chip select did not follow command");
    a_cs_same: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE3]
        $rose(mem_cmd.cmd_valid) && !$past(s.config_reg[STC_CMD_DLY_BIT]) |-> mem_cmd.cs)
        else $error("chip select late with drive bit clear");
    a_par_off: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE4]
        !$past(s.config_reg[STC_PAR_EN_BIT]) |-> parity_oe_b && !s.par_err)
        else $error("parity active while disabled");
    a_par_drive: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE5]
        s.config_reg[STC_PAR_EN_BIT] && wr_active && !wr_from_cpu |=> !parity_oe_b)
        else $error("parity not driven on write");
    a_cpu_par: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE6]
        s.config_reg[STC_CPU_PAR_BIT] && wr_from_cpu |=> parity_oe_b)
        else $error("parity driven on processor write");
    a_ref_off: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE8]
        s.config_reg[STC_REF_LSB +: 6] == STC_REF_OFF |=> !s.ref_pend)
        else $error("refresh pending while disabled");
    a_ref_arb: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE9]
        $rose(mem_cmd.refresh) |-> $past(arb_point))
        else $error("refresh issued outside arbitration point");
    a_ref_reload: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE10]
        ref_expire |=> s.ref_cnt == $past(s.config_reg[STC_REF_LSB +: 6]))
        else $error("refresh timer not reloaded on expiry");
    a_cs_late: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE3]
        $rose(mem_cmd.cmd_valid) && $past(s.config_reg[STC_CMD_DLY_BIT]) |-> cs_late)
        else $error("chip select not one cycle after command");
    a_ref_all: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE11]
        mem_cmd.cmd_valid |-> mem_cmd.refresh)
        else $error("command other than all-array refresh");
    a_ref_issue: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE9]
        s.seq == STC_IDLE && s.ref_pend && arb_point |=> mem_cmd.cmd_valid && mem_cmd.refresh)
        else $error("pending refresh not issued at arbitration point");
    a_ref_keep: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE9]
        s.ref_pend && !arb_point && s.config_reg[STC_REF_LSB +: 6] != STC_REF_OFF |=> s.ref_pend)
        else $error("pending refresh lost before arbitration point");
    a_tick_gap: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE13]
        tick |=> !tick [*8])
        else $error("prescaler tick too frequent");
    a_cfg_zero: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE13]
        ar_fire && axi_req.araddr[7:0] == STC_ADDR_CONFIG
        |=> (axi_rsp.rdata & ~STC_CONFIG_WMASK) == 32'h0000_0000)
        else $error("unused config bits read nonzero");
    a_rc_full: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE1]
        $rose(activate_ok) |-> gap_cnt >= gap_need)
        else $error("activate allowed before full row cycle time");
endmodule
`default_nettype wire

// ==== sim/stc_mem_model.sv ====
// Behavioural model of the SDRAM arrays returning read beats with parity
`timescale 1ns/1ps
`default_nettype none
module stc_mem_model (
    input wire logic core_clk,
    input wire logic rd_go,
    input wire logic bad,
    input wire logic [31:0] word,
    output logic rd_valid = 1'b0,
    output logic [31:0] rd_data = 32'h0000_0000,
    output logic [3:0] parity_in = 4'h0
);
    // ****************************************
    // Read beat, bad flag corrupts parity
    // ****************************************
    always @(posedge core_clk) begin
        rd_valid <= rd_go;
        if (rd_go) begin
            rd_data <= word;
            for (int i = 0; i < 4; i++) begin
                parity_in[i] <= (^word[8*i +: 8]) ^ bad;
            end
        end else begin
            rd_data <= ~rd_data;
            parity_in <= ~parity_in;
        end
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the SDRAM timing and refresh block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import stc_pkg::*;
    logic core_clk, rst_b, arb_point, wr_active, wr_from_cpu, rd_go, bad;
    logic activate_ok, parity_oe_b, irq, rd_valid;
    logic [31:0] wr_data, rd_data, rdat;
    logic [3:0] parity_in, parity_out;
    logic [1:0] resp;
    stc_axi_req_t axi_req;
    stc_axi_rsp_t axi_rsp;
    stc_mem_cmd_t mem_cmd;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int t_cmd = 0;
    stc_sdram_timing dut (.core_clk(core_clk), .rst_b(rst_b), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .arb_point(arb_point), .activate_req(1'b0),
        .activate_ok(activate_ok), .wr_active(wr_active), .wr_from_cpu(wr_from_cpu),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .parity_in(parity_in),
        .parity_out(parity_out), .parity_oe_b(parity_oe_b), .mem_cmd(mem_cmd), .irq(irq));
    stc_mem_model mem (.core_clk(core_clk), .rd_go(rd_go), .bad(bad), .word(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .parity_in(parity_in));
    // ****************************************
    // Clock, timeout, report
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task complete_run;
        if (fail_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ****************************************
    // Register bus
    // ****************************************
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        n = 0;
        axi_req.awaddr <= {24'h0, a};
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hF;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (!(axi_rsp.bvalid && axi_req.bready) && n < 50);
        axi_req.bready <= 1'b0;
        chk("bvalid", 1, axi_rsp.bvalid);
        chk("bresp", STC_RESP_OKAY, axi_rsp.bresp);
    endtask
    task rd(input logic [7:0] a);
        int n;
        @(posedge core_clk);
        n = 0;
        axi_req.araddr <= {24'h0, a};
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (!(axi_rsp.rvalid && axi_req.rready) && n < 50);
        chk("rvalid", 1, axi_rsp.rvalid);
        rdat = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask
    task pulse_read(input logic b);
        @(posedge core_clk);
        rd_go <= 1'b1;
        bad <= b;
        @(posedge core_clk);
        rd_go <= 1'b0;
    endtask
    task see_ref(input int rc_len, input int dly);
        int n;
        n = 0;
        @(posedge core_clk);
        arb_point <= 1'b1;
        @(negedge core_clk);
        while (mem_cmd.cmd_valid !== 1'b1 && n < 80) begin
            @(negedge core_clk);
            n++;
        end
        t_cmd = cyc;
        chk("refresh", 1, mem_cmd.refresh);
        n = 0;
        while (activate_ok !== 1'b1 && n < 20) begin
            if (n == dly) chk("cs", 1, mem_cmd.cs);
            if (n < dly) chk("cs_early", 0, mem_cmd.cs);
            n++;
            @(posedge core_clk);
            arb_point <= 1'b0;
            @(negedge core_clk);
        end
        chk("act_block", rc_len + dly, n);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_regs;
        rd(STC_ADDR_CONFIG);
        chk("cfg_reset", 32'h0, rdat);
        wr(STC_ADDR_CONFIG, 32'hFFFF_FFFF);
        rd(STC_ADDR_CONFIG);
        chk("cfg_bits", 32'h003F_3F00, rdat);
        rd(8'h0C);
        chk("bad_resp", STC_RESP_SLVERR, resp);
        chk("bad_data", 32'h0, rdat);
        wr(STC_ADDR_CONFIG, 32'h0000_0100);
        rd(STC_ADDR_STATUS);
    endtask
    task t_refresh;
        int hits;
        hits = 0;
        wr(STC_ADDR_MASK, 32'h0);
        wr(STC_ADDR_CONFIG, 32'h0001_0100);
        repeat (60) begin
            @(negedge core_clk);
            if (mem_cmd.cmd_valid !== 1'b0) hits++;
        end
        chk("ref_held", 0, hits);
        @(posedge core_clk);
        arb_point <= 1'b1;
        see_ref(4, 0);
        @(posedge core_clk);
        arb_point <= 1'b0;
        @(negedge core_clk);
        chk("irq_masked", 0, irq);
        wr(STC_ADDR_MASK, 32'h1);
        @(negedge core_clk);
        chk("irq_on", 1, irq);
        rd(STC_ADDR_STATUS);
        chk("status_ref", 32'h1, rdat);
        @(negedge core_clk);
        chk("irq_off", 0, irq);
    endtask
    task t_reload;
        int t0;
        wr(STC_ADDR_CONFIG, 32'h0000_0000);
        wr(STC_ADDR_CONFIG, 32'h0002_0F00);
        see_ref(10, 1);
        see_ref(10, 1);
        t0 = t_cmd;
        see_ref(10, 1);
        chk("ref_period", 32, t_cmd - t0);
    endtask
    task t_parity;
        int hits;
        hits = 0;
        wr(STC_ADDR_CONFIG, 32'h0000_0100);
        rd(STC_ADDR_STATUS);
        @(posedge core_clk);
        wr_active <= 1'b1;
        arb_point <= 1'b1;
        wr_data <= 32'h8C31_F703;
        pulse_read(1'b1);
        repeat (100) begin
            @(negedge core_clk);
            if (mem_cmd.cmd_valid !== 1'b0) hits++;
        end
        chk("ref_off", 0, hits);
        chk("par_hiz", 1, parity_oe_b);
        rd(STC_ADDR_STATUS);
        chk("no_check", 32'h0, rdat);
        wr(STC_ADDR_CONFIG, 32'h0000_1100);
        repeat (2) @(negedge core_clk);
        chk("par_drive", 0, parity_oe_b);
        chk("par_value", 4'hE, parity_out);
        pulse_read(1'b1);
        repeat (4) @(negedge core_clk);
        rd(STC_ADDR_STATUS);
        chk("par_err", 32'h2, rdat);
        wr(STC_ADDR_CONFIG, 32'h0000_3100);
        @(posedge core_clk);
        wr_from_cpu <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk("cpu_par", 1, parity_oe_b);
        @(posedge core_clk);
        wr_from_cpu <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk("dev_par", 0, parity_oe_b);
    endtask
    initial begin
        rst_b = 1'b0;
        arb_point = 1'b0;
        wr_active = 1'b0;
        wr_from_cpu = 1'b0;
        wr_data = 32'h0;
        rd_go = 1'b0;
        bad = 1'b0;
        axi_req = '0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs();
        t_refresh();
        t_reload();
        t_parity();
        complete_run();
    end
endmodule
`default_nettype wire
